// >>> rtl/mwis_top.sv
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mwis_cfg.svh"

// Functional notes
// - enable bit 3 gates statistics interrupt
// - enable bit 2 gates host error interrupt
// - enable bit 1 gates link change interrupt
// - enable bit 0 gates user command interrupt
// - per-channel receive-threshold pending, bits 7..0
// - per-channel receive pending, bits 7..0
// - per-channel transmit pending, bits 7..0
// - misc status read-only, resets zero, bits 3..0
// - misc status bit follows source pending level
module mwis_top (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite register bus
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  output var  mwis_pkg::mwis_word_t hrdata,
  // miscellaneous pending levels from the mac and management units
  input  wire logic                 statistics_irq,
  input  wire logic                 host_error_irq,
  input  wire logic                 link_change_irq,
  input  wire logic                 user_cmd_done_irq,
  // per-channel pending levels
  input  wire mwis_pkg::mwis_chan_t rx_threshold_irq,
  input  wire mwis_pkg::mwis_chan_t rx_irq,
  input  wire mwis_pkg::mwis_chan_t tx_irq,
  // enabled miscellaneous interrupts toward the host
  output var  logic                 statistics_irq_host_q,
  output var  logic                 host_error_irq_host_q,
  output var  logic                 link_change_irq_host_q,
  output var  logic                 user_cmd_done_irq_host_q,
  // summary interrupt
  output var  logic                 irq_q
);
  import mwis_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  mwis_misc_t misc_irq_enable_q;
  mwis_misc_t misc_irq_status_q;
  mwis_chan_t rx_threshold_pending_bits_q;
  mwis_chan_t rx_pending_bits_q;
  mwis_chan_t tx_pending_bits_q;
  mwis_evt_t  evt_mask_q;
  mwis_evt_t  evt_flag;
  mwis_evt_t  evt_src;
  mwis_evt_t  evt_clr;

  logic       wr_en;
  mwis_addr_t wr_addr;
  mwis_word_t wr_data;
  mwis_addr_t rd_addr;
  mwis_word_t rd_data;

  logic       statistics_irq_flag;
  logic       host_error_irq_flag;
  logic       link_change_irq_flag;
  logic       user_cmd_done_irq_flag;
  logic       wr_misc_en;
  logic       wr_evt_stat;
  logic       wr_evt_mask;

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  mwis_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  assign wr_misc_en  = wr_en && (wr_addr == `MWIS_OFS_MISC_EN);
  assign wr_evt_stat = wr_en && (wr_addr == `MWIS_OFS_EVT_STAT);
  assign wr_evt_mask = wr_en && (wr_addr == `MWIS_OFS_EVT_MASK);

  ////////////////////////////////////////////////////////////////////////
  // miscellaneous enable register, only bits 3..0 are writable

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_irq_enable_q <= `MWIS_RST_MISC_EN;
    end else if (wr_misc_en) begin
      misc_irq_enable_q <= wr_data[`MWIS_MISC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // miscellaneous pending capture; sources share hclk, no synchroniser

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_irq_status_q <= `MWIS_RST_MISC_EN;
    end else begin
      misc_irq_status_q[`MWIS_BIT_STAT] <= statistics_irq;
      misc_irq_status_q[`MWIS_BIT_HOST] <= host_error_irq;
      misc_irq_status_q[`MWIS_BIT_LINK] <= link_change_irq;
      misc_irq_status_q[`MWIS_BIT_USER] <= user_cmd_done_irq;
    end
  end

  assign statistics_irq_flag    = misc_irq_status_q[`MWIS_BIT_STAT];
  assign host_error_irq_flag    = misc_irq_status_q[`MWIS_BIT_HOST];
  assign link_change_irq_flag   = misc_irq_status_q[`MWIS_BIT_LINK];
  assign user_cmd_done_irq_flag = misc_irq_status_q[`MWIS_BIT_USER];

  ////////////////////////////////////////////////////////////////////////
  // per-channel pending capture

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_threshold_pending_bits_q <= `MWIS_RST_PEND;
    end else begin
      rx_threshold_pending_bits_q <= rx_threshold_irq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pending_bits_q <= `MWIS_RST_PEND;
    end else begin
      rx_pending_bits_q <= rx_irq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pending_bits_q <= `MWIS_RST_PEND;
    end else begin
      tx_pending_bits_q <= tx_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enabled interrupts toward the host
  // masking only gates the output; the captured pending stays visible

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      statistics_irq_host_q <= 1'b0;
    end else begin
      statistics_irq_host_q <= statistics_irq_flag &&
                               misc_irq_enable_q[`MWIS_BIT_STAT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_error_irq_host_q <= 1'b0;
    end else begin
      host_error_irq_host_q <= host_error_irq_flag &&
                               misc_irq_enable_q[`MWIS_BIT_HOST];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_change_irq_host_q <= 1'b0;
    end else begin
      link_change_irq_host_q <= link_change_irq_flag &&
                                misc_irq_enable_q[`MWIS_BIT_LINK];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_cmd_done_irq_host_q <= 1'b0;
    end else begin
      user_cmd_done_irq_host_q <= user_cmd_done_irq_flag &&
                                  misc_irq_enable_q[`MWIS_BIT_USER];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags: rising edge of each misc pending, and of
  // the OR of all channels in each per-channel group

  assign evt_src = {|tx_pending_bits_q,
                    |rx_pending_bits_q,
                    |rx_threshold_pending_bits_q,
                    misc_irq_status_q};

  // write one to clear; a clear never hides a same-cycle event
  assign evt_clr = wr_evt_stat ? wr_data[`MWIS_EVT_W-1:0] : `MWIS_RST_EVT;

  mwis_evt_sticky u_sticky (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (evt_src),
    .clr     (evt_clr),
    .flag_q  (evt_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // event mask, same layout as the event flags

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_mask_q <= `MWIS_RST_EVT;
    end else if (wr_evt_mask) begin
      evt_mask_q <= wr_data[`MWIS_EVT_W-1:0];
    end
  end

  // level output, one cycle behind the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_flag & evt_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits and unmapped offsets read zero

  always_comb begin
    rd_data = `MWIS_RST_WORD;
    case (rd_addr)
      `MWIS_OFS_MISC_EN: begin
        rd_data[`MWIS_MISC_W-1:0] = misc_irq_enable_q;
      end
      `MWIS_OFS_RXTH_STAT: begin
        rd_data[`MWIS_CHAN_N-1:0] = rx_threshold_pending_bits_q;
      end
      `MWIS_OFS_RX_STAT: begin
        rd_data[`MWIS_CHAN_N-1:0] = rx_pending_bits_q;
      end
      `MWIS_OFS_TX_STAT: begin
        rd_data[`MWIS_CHAN_N-1:0] = tx_pending_bits_q;
      end
      `MWIS_OFS_MISC_STAT: begin
        rd_data[`MWIS_MISC_W-1:0] = misc_irq_status_q;
      end
      `MWIS_OFS_MISC_ALIAS: begin
        // misc_status_alias: second name, same bits
        rd_data[`MWIS_MISC_W-1:0] = misc_irq_status_q;
      end
      `MWIS_OFS_EVT_STAT: begin
        rd_data[`MWIS_EVT_W-1:0] = evt_flag;
      end
      `MWIS_OFS_EVT_MASK: begin
        rd_data[`MWIS_EVT_W-1:0] = evt_mask_q;
      end
      default: begin
        rd_data = `MWIS_RST_WORD;
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> rtl/mwis_cfg.svh
`ifndef MWIS_CFG_SVH
`define MWIS_CFG_SVH

// register byte offsets, low address byte, word aligned
`define MWIS_OFS_MISC_EN    8'h00
`define MWIS_OFS_RXTH_STAT  8'h04
`define MWIS_OFS_RX_STAT    8'h08
`define MWIS_OFS_TX_STAT    8'h0c
`define MWIS_OFS_MISC_STAT  8'h10
`define MWIS_OFS_MISC_ALIAS 8'h14
`define MWIS_OFS_EVT_STAT   8'h18
`define MWIS_OFS_EVT_MASK   8'h1c

// field widths
`define MWIS_MISC_W 4
`define MWIS_CHAN_N 8
`define MWIS_EVT_W  7

// miscellaneous field positions, shared by enable and status
`define MWIS_BIT_STAT 3
`define MWIS_BIT_HOST 2
`define MWIS_BIT_LINK 1
`define MWIS_BIT_USER 0

// event status and mask positions above the misc bits
`define MWIS_EVT_RXTH 4
`define MWIS_EVT_RX   5
`define MWIS_EVT_TX   6

// reset values
`define MWIS_RST_MISC_EN 4'h0
`define MWIS_RST_PEND    8'h00
`define MWIS_RST_EVT     7'h00
`define MWIS_RST_WORD    32'h0000_0000

// bus encodings
`define MWIS_HSIZE_WORD 3'h2
`define MWIS_HRESP_OKAY 1'h0

`endif

// >>> rtl/mwis_pkg.sv
package mwis_pkg;

  typedef enum logic [0:0] {
    MWIS_ST_IDLE   = 1'b0,
    MWIS_ST_RDWAIT = 1'b1
  } mwis_bus_state_t;

  typedef logic [7:0]  mwis_addr_t;
  typedef logic [31:0] mwis_word_t;
  typedef logic [3:0]  mwis_misc_t;
  typedef logic [7:0]  mwis_chan_t;
  typedef logic [6:0]  mwis_evt_t;

endpackage

// >>> rtl/mwis_evt_sticky.sv
`timescale 1ns/100ps
`default_nettype none
`include "mwis_cfg.svh"

module mwis_evt_sticky (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // event levels and write-one clear
  input  wire mwis_pkg::mwis_evt_t src,
  input  wire mwis_pkg::mwis_evt_t clr,
  // sticky flags
  output var  mwis_pkg::mwis_evt_t flag_q
);
  import mwis_pkg::*;

  mwis_evt_t src_prev_q;

  ////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < `MWIS_EVT_W; gi = gi + 1) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          src_prev_q[gi] <= 1'b0;
        end else begin
          src_prev_q[gi] <= src[gi];
        end
      end

      // a rising edge in the clear cycle is kept: set beats clear
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_q[gi] <= 1'b0;
        end else if (src[gi] && !src_prev_q[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (clr[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/mwis_ahb_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "mwis_cfg.svh"

module mwis_ahb_slave (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave side
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic                hreadyout,
  output var  logic                hresp,
  output var  mwis_pkg::mwis_word_t hrdata,
  // register file side
  output var  logic                wr_en,
  output var  mwis_pkg::mwis_addr_t wr_addr,
  output var  mwis_pkg::mwis_word_t wr_data,
  output var  mwis_pkg::mwis_addr_t rd_addr,
  input  wire mwis_pkg::mwis_word_t rd_data
);
  import mwis_pkg::*;

  mwis_bus_state_t st_q;
  logic            wr_pend_q;
  mwis_addr_t      addr_q;
  logic            take;

  ////////////////////////////////////////////////////////////////////////
  // htrans[1] covers nonseq and seq; sub-word writes are dropped
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
    end else if (take) begin
      addr_q    <= {haddr[7:2], 2'h0};
      wr_pend_q <= hwrite && (hsize == `MWIS_HSIZE_WORD);
    end else if (hready) begin
      wr_pend_q <= 1'b0;
    end
  end

  // reads take one wait state so a write just done is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= MWIS_ST_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= `MWIS_RST_WORD;
    end else begin
      case (st_q)
        MWIS_ST_IDLE: begin
          if (take && !hwrite) begin
            st_q      <= MWIS_ST_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        MWIS_ST_RDWAIT: begin
          st_q      <= MWIS_ST_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= rd_data;
        end
        default: begin
          st_q      <= MWIS_ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `MWIS_HRESP_OKAY;
    end else begin
      hresp <= `MWIS_HRESP_OKAY;
    end
  end

  assign wr_en   = wr_pend_q && hready;
  assign wr_addr = addr_q;
  assign wr_data = hwdata;
  assign rd_addr = addr_q;

endmodule
`default_nettype wire

// >>> bench/mwis_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mwis_top_sva (
  // clock and reset
  input wire logic                 hclk,
  input wire logic                 hresetn,
  // bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire mwis_pkg::mwis_word_t hrdata,
  // sources
  input wire logic                 statistics_irq,
  input wire logic                 host_error_irq,
  input wire logic                 link_change_irq,
  input wire logic                 user_cmd_done_irq,
  input wire mwis_pkg::mwis_chan_t rx_threshold_irq,
  input wire mwis_pkg::mwis_chan_t rx_irq,
  input wire mwis_pkg::mwis_chan_t tx_irq,
  // host side
  input wire logic                 statistics_irq_host_q,
  input wire logic                 host_error_irq_host_q,
  input wire logic                 link_change_irq_host_q,
  input wire logic                 user_cmd_done_irq_host_q
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_go;
  logic [3:0] misc_in;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign misc_in = {statistics_irq, host_error_irq, link_change_irq,
                    user_cmd_done_irq};
  ////////////////////////////////////////////////////////////////////////
  property p_rd_wait;
    rd_go |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  // a host output never rises without its source pending
  property p_host_stat;
    statistics_irq_host_q |-> $past(statistics_irq, 2);
  endproperty
  a_host_stat: assert property (p_host_stat)
    else $error("statistics host output without source");
  property p_host_err;
    host_error_irq_host_q |-> $past(host_error_irq, 2);
  endproperty
  a_host_err: assert property (p_host_err)
    else $error("host error output without source");
  property p_host_link;
    link_change_irq_host_q |-> $past(link_change_irq, 2);
  endproperty
  a_host_link: assert property (p_host_link)
    else $error("link change output without source");
  property p_host_user;
    user_cmd_done_irq_host_q |-> $past(user_cmd_done_irq, 2);
  endproperty
  a_host_user: assert property (p_host_user)
    else $error("user output without source");
  // read data judged only while the source holds still
  property p_rd_rxth;
    rd_go && haddr[7:2] == 6'h01 && $stable(rx_threshold_irq)
      ##1 $stable(rx_threshold_irq)
      |=> hrdata == {24'h00, $past(rx_threshold_irq)};
  endproperty
  a_rd_rxth: assert property (p_rd_rxth)
    else $error("rx threshold status read wrong");
  property p_rd_rx;
    rd_go && haddr[7:2] == 6'h02 && $stable(rx_irq) ##1 $stable(rx_irq)
      |=> hrdata == {24'h00, $past(rx_irq)};
  endproperty
  a_rd_rx: assert property (p_rd_rx)
    else $error("rx status read wrong");
  property p_rd_tx;
    rd_go && haddr[7:2] == 6'h03 && $stable(tx_irq) ##1 $stable(tx_irq)
      |=> hrdata == {24'h00, $past(tx_irq)};
  endproperty
  a_rd_tx: assert property (p_rd_tx)
    else $error("tx status read wrong");
  property p_rd_misc;
    rd_go && haddr[7:2] == 6'h04 && $stable(misc_in) ##1 $stable(misc_in)
      |=> hrdata == {28'h0, $past(misc_in)};
  endproperty
  a_rd_misc: assert property (p_rd_misc)
    else $error("misc status read wrong");
endmodule
bind mwis_top mwis_top_sva u_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hrdata, .statistics_irq,
  .host_error_irq, .link_change_irq, .user_cmd_done_irq,
  .rx_threshold_irq, .rx_irq, .tx_irq, .statistics_irq_host_q,
  .host_error_irq_host_q, .link_change_irq_host_q,
  .user_cmd_done_irq_host_q);
`default_nettype wire

// >>> bench/mwis_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// mac and management sources: levels change only at a clock edge
module mwis_src_model (
  // clock
  input  wire logic                 hclk,
  // commanded levels
  input  wire mwis_pkg::mwis_misc_t misc_cmd,
  input  wire mwis_pkg::mwis_chan_t rxth_cmd,
  input  wire mwis_pkg::mwis_chan_t rx_cmd,
  input  wire mwis_pkg::mwis_chan_t tx_cmd,
  // pending levels
  output var  logic                 statistics_irq,
  output var  logic                 host_error_irq,
  output var  logic                 link_change_irq,
  output var  logic                 user_cmd_done_irq,
  output var  mwis_pkg::mwis_chan_t rx_threshold_irq,
  output var  mwis_pkg::mwis_chan_t rx_irq,
  output var  mwis_pkg::mwis_chan_t tx_irq
);
  always_ff @(posedge hclk) begin
    {statistics_irq, host_error_irq, link_change_irq,
     user_cmd_done_irq} <= misc_cmd;
    rx_threshold_irq <= rxth_cmd;
    rx_irq <= rx_cmd;
    tx_irq <= tx_cmd;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mwis_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  wsize = 3'h2;
  wire logic   hreadyout;
  wire logic   hresp;
  wire logic   irq_q;
  wire logic   stat_s, herr_s, link_s, user_s;
  wire logic [3:0] host_q;
  wire mwis_word_t hrdata;
  wire mwis_chan_t rxth_s, rx_s, tx_s;
  mwis_misc_t  misc_cmd = 4'h0;
  mwis_chan_t  rxth_cmd = 8'h00;
  mwis_chan_t  rx_cmd = 8'h00;
  mwis_chan_t  tx_cmd = 8'h00;
  mwis_word_t  rv;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #2 hclk = ~hclk;
  mwis_src_model src (.hclk, .misc_cmd, .rxth_cmd, .rx_cmd, .tx_cmd,
    .statistics_irq(stat_s), .host_error_irq(herr_s),
    .link_change_irq(link_s), .user_cmd_done_irq(user_s),
    .rx_threshold_irq(rxth_s), .rx_irq(rx_s), .tx_irq(tx_s));
  mwis_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .statistics_irq(stat_s), .host_error_irq(herr_s),
    .link_change_irq(link_s), .user_cmd_done_irq(user_s),
    .rx_threshold_irq(rxth_s), .rx_irq(rx_s), .tx_irq(tx_s),
    .statistics_irq_host_q(host_q[3]), .host_error_irq_host_q(host_q[2]),
    .link_change_irq_host_q(host_q[1]),
    .user_cmd_done_irq_host_q(host_q[0]), .irq_q);
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input mwis_word_t seen, exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer of size wsize, read data taken at the closing edge
  task automatic bus(input mwis_addr_t a, input logic w,
                     input mwis_word_t d, output mwis_word_t r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= wsize;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // every offset plus one unmapped reads zero after reset
    for (int a = 0; a <= 32; a += 4) begin
      bus(a[7:0], 1'b0, 32'h0, rv);
      chk(rv, 32'h0, "reset word");
    end
    bus(8'h00, 1'b1, 32'hffff_ffff, rv);
    bus(8'h00, 1'b0, 32'h0, rv);
    chk(rv, 32'h0000_000f, "enable");
    // byte-wide and deselected writes leave the enables alone
    wsize = 3'h0;
    bus(8'h00, 1'b1, 32'h0, rv);
    wsize = 3'h2;
    hsel <= 1'b0;
    bus(8'h00, 1'b1, 32'h0, rv);
    hsel <= 1'b1;
    bus(8'h00, 1'b0, 32'h0, rv);
    chk(rv, 32'h0000_000f, "enable kept");
    for (int i = 0; i < 4; i++) begin
      // all other enables on: the pending source must stay hidden
      bus(8'h00, 1'b1, 32'hf ^ (32'h1 << i), rv);
      misc_cmd <= 4'h1 << i;
      repeat (4) @(posedge hclk);
      chk({28'h0, host_q}, 32'h0, "host off");
      bus(8'h00, 1'b1, 32'h1 << i, rv);
      repeat (4) @(posedge hclk);
      chk({28'h0, host_q}, 32'h1 << i, "host on");
      bus(8'h00, 1'b1, 32'h0, rv);
      bus(8'h10, 1'b0, 32'h0, rv);
      chk(rv, 32'h1 << i, "misc status");
      bus(8'h14, 1'b0, 32'h0, rv);
      chk(rv, 32'h1 << i, "misc alias");
      misc_cmd <= 4'h0;
      repeat (4) @(posedge hclk);
      bus(8'h10, 1'b0, 32'h0, rv);
      chk(rv, 32'h0, "misc idle");
    end
    for (int n = 0; n < 8; n++) begin
      rxth_cmd <= 8'h01 << n;
      rx_cmd <= 8'h80 >> n;
      tx_cmd <= ~(8'h01 << n);
      repeat (4) @(posedge hclk);
      bus(8'h04, 1'b0, 32'h0, rv);
      chk(rv, 32'h1 << n, "rx threshold");
      bus(8'h08, 1'b0, 32'h0, rv);
      chk(rv, 32'h80 >> n, "rx");
      bus(8'h0c, 1'b0, 32'h0, rv);
      chk(rv, 32'hff ^ (32'h1 << n), "tx");
    end
    // read-only places ignore writes
    bus(8'h0c, 1'b1, 32'h0, rv);
    bus(8'h10, 1'b1, 32'hf, rv);
    bus(8'h0c, 1'b0, 32'h0, rv);
    chk(rv, 32'h7f, "tx after write");
    bus(8'h10, 1'b0, 32'h0, rv);
    chk(rv, 32'h0, "misc after write");
    // every source has risen once by now
    bus(8'h18, 1'b0, 32'h0, rv);
    chk(rv, 32'h7f, "all events");
    // event raised, masked, unmasked and cleared
    rxth_cmd <= 8'h00;
    rx_cmd <= 8'h00;
    tx_cmd <= 8'h00;
    repeat (4) @(posedge hclk);
    bus(8'h18, 1'b1, 32'h7f, rv);
    bus(8'h18, 1'b0, 32'h0, rv);
    chk(rv, 32'h0, "events cleared");
    bus(8'h1c, 1'b1, 32'h0, rv);
    misc_cmd <= 4'h8;
    repeat (4) @(posedge hclk);
    bus(8'h18, 1'b0, 32'h0, rv);
    chk(rv, 32'h08, "event");
    chk({31'h0, irq_q}, 32'h0, "irq masked");
    bus(8'h1c, 1'b1, 32'h08, rv);
    bus(8'h1c, 1'b0, 32'h0, rv);
    chk(rv, 32'h08, "mask");
    repeat (4) @(posedge hclk);
    chk({31'h0, irq_q}, 32'h1, "irq");
    bus(8'h18, 1'b1, 32'h08, rv);
    repeat (4) @(posedge hclk);
    chk({31'h0, irq_q}, 32'h0, "irq cleared");
    bus(8'h10, 1'b0, 32'h0, rv);
    chk(rv, 32'h8, "pending kept");
    test_done;
  end
endmodule
`default_nettype wire
